/* lms_ctrl_mode.v */
`include "lms_ctrl_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module lms_ctrl_mode (
    input  wire       REF_CLK,
    input  wire       RESET,
    input  wire       HW_RESET_N,
    input  wire [1:0] CONTROL_MODE_SELECT,
    input  wire       DRIVER_FLOAT_CONTROL,
    input  wire       CHIP_SELECT_N,
    input  wire       SERIAL_CLK,
    input  wire       SERIAL_EDGE_SELECT,
    input  wire       SERIAL_IN,
    output wire       SERIAL_OUT,
    output wire       SERIAL_OUT_OE,
    input  wire [7:0] AD_IN,
    output wire [7:0] AD_OUT,
    output wire       AD_OE,
    input  wire       DATA_STROBE_OR_READ_N,
    input  wire       READ_WRITE_OR_WRITE_N,
    input  wire       ADDRESS_LATCH_STROBE,
    output wire       ACK_OR_READY,
    output wire       ACK_OR_READY_OE,
    output wire       INT_N_OUT,
    output wire       INT_N_OE,
    input  wire [3:0] LINE_TEMPLATE_SELECT,
    input  wire       RECV_CLOCK_EDGE_SELECT,
    input  wire [1:0] LOOPBACK_SELECT,
    input  wire [1:0] TRANSMIT_SEQUENCE_SELECT,
    input  wire [1:0] JITTER_ATTENUATOR_SELECT,
    input  wire       MONITOR_GAIN_SELECT,
    input  wire       TERMINATION_SELECT,
    input  wire       RECEIVE_GAIN_RANGE_SELECT,
    input  wire       RECEIVER_POWERDOWN,
    input  wire [1:0] DATAPATH_OPERATING_MODE,
    output wire       DEVICE_RESET,
    output wire [1:0] CONTROL_MODE,
    output wire       LINE_STANDARD_T1,
    output wire       TX_DRIVER_OE,
    output wire [7:0] GENERAL_CONFIG,
    output wire [3:0] CFG_TEMPLATE,
    output wire       CFG_TERM_SEL,
    output wire       CFG_RECV_CLOCK_EDGE,
    output wire [1:0] CFG_LOOPBACK,
    output wire [1:0] CFG_TX_SEQUENCE,
    output wire [1:0] CFG_JITTER_ATTEN,
    output wire       CFG_MONITOR_GAIN,
    output wire       CFG_RECEIVE_GAIN,
    output wire       CFG_RECEIVER_PD,
    output wire [1:0] CFG_DATAPATH_MODE
);
    wire [`LMS_SYNC_W-1:0] raw_pins;
    wire [`LMS_SYNC_W-1:0] syn;

    assign raw_pins = {HW_RESET_N, CONTROL_MODE_SELECT, DRIVER_FLOAT_CONTROL,
                       CHIP_SELECT_N, SERIAL_CLK, SERIAL_EDGE_SELECT, SERIAL_IN,
                       AD_IN, DATA_STROBE_OR_READ_N, READ_WRITE_OR_WRITE_N,
                       ADDRESS_LATCH_STROBE, LINE_TEMPLATE_SELECT,
                       RECV_CLOCK_EDGE_SELECT, LOOPBACK_SELECT,
                       TRANSMIT_SEQUENCE_SELECT, JITTER_ATTENUATOR_SELECT,
                       MONITOR_GAIN_SELECT, TERMINATION_SELECT,
                       RECEIVE_GAIN_RANGE_SELECT, RECEIVER_POWERDOWN,
                       DATAPATH_OPERATING_MODE};

    // every pin except RESET goes through two flops before any logic reads it
    lms_sync #(
        .W (`LMS_SYNC_W)
    ) u_sync (
        .clk  (REF_CLK),
        .din  (raw_pins),
        .dout (syn)
    );

    wire       s_rst_n     = syn[35];
    wire [1:0] s_mode      = syn[34:33];
    wire       s_float     = syn[32];
    wire       s_cs_n      = syn[31];
    wire       s_sclk      = syn[30];
    wire       s_edge      = syn[29];
    wire       s_sdi       = syn[28];
    wire [7:0] s_ad        = syn[27:20];
    wire       s_data_strobe_or_read_n   = syn[19];
    wire       s_rw_wr_n   = syn[18];
    wire       s_ale       = syn[17];
    wire [3:0] s_template  = syn[16:13];
    wire [12:0] s_hw_pins  = syn[12:0];

    // hardware reset qualification
    reg [`LMS_RST_CNT_W-1:0] rst_cnt_ff;
    reg                      hw_rst_ff;
    wire                     dev_rst = RESET | hw_rst_ff;

    always @(posedge REF_CLK) begin
        if (RESET) begin
            rst_cnt_ff <= {`LMS_RST_CNT_W{1'b0}};
            hw_rst_ff  <= 1'b0;
        end else if (s_rst_n) begin
            rst_cnt_ff <= {`LMS_RST_CNT_W{1'b0}};
            hw_rst_ff  <= 1'b0;
        end else if (rst_cnt_ff >= `LMS_RST_MIN_CYC) begin
            hw_rst_ff  <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
        end
    end

    // control mode is a strap: tracked only while reset holds
    reg [1:0] mode_ff;

    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            mode_ff <= s_mode;
        end
    end

    wire is_hw     = (mode_ff == `LMS_MODE_HW);
    wire is_serial = (mode_ff == `LMS_MODE_SERIAL);
    wire is_moto   = (mode_ff == `LMS_MODE_MOTOROLA);
    wire is_intel  = (mode_ff == `LMS_MODE_INTEL);

    // register file
    reg  [7:0] gen_cfg_ff;
    wire       wr_en;
    wire [6:0] wr_addr;
    wire [7:0] wr_data;
    reg  [7:0] rd_data;
    wire [6:0] rd_addr;
    wire       line_t1;
    wire [7:0] status_val = {4'h0, s_float, line_t1, mode_ff};

    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            gen_cfg_ff <= `LMS_GEN_CFG_RST;
        end else if (wr_en && !is_hw && wr_addr == `LMS_ADDR_GEN_CFG) begin
            gen_cfg_ff <= wr_data;
        end
    end

    always @* begin
        case (rd_addr)
            `LMS_ADDR_GEN_CFG: rd_data = gen_cfg_ff;
            `LMS_ADDR_STATUS:  rd_data = status_val;
            default:           rd_data = `LMS_READ_NONE;
        endcase
    end

    // serial port
    reg       sclk_p_ff;
    reg [2:0] bit_cnt_ff;
    reg       phase_ff;
    reg       ser_rd_ff;
    reg [6:0] ser_addr_ff;
    reg [7:0] rx_sh_ff;
    reg [7:0] tx_sh_ff;
    reg       sdo_ff;
    reg       ser_wr_ff;
    reg [7:0] ser_wdata_ff;

    wire rise = s_sclk & ~sclk_p_ff;
    wire fall = ~s_sclk & sclk_p_ff;
    wire samp_edge = s_edge ? rise : fall;
    wire lnch_edge = s_edge ? fall : rise;
    wire [7:0] rx_next = {rx_sh_ff[6:0], s_sdi};
    wire ser_act = is_serial & ~s_cs_n;

    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            sclk_p_ff    <= 1'b0;
            bit_cnt_ff   <= 3'h0;
            phase_ff     <= 1'b0;
            ser_rd_ff    <= 1'b0;
            ser_addr_ff  <= 7'h00;
            rx_sh_ff     <= 8'h00;
            tx_sh_ff     <= 8'h00;
            sdo_ff       <= 1'b0;
            ser_wr_ff    <= 1'b0;
            ser_wdata_ff <= 8'h00;
        end else begin
            sclk_p_ff <= s_sclk;
            ser_wr_ff <= 1'b0;
            if (!ser_act) begin
                bit_cnt_ff <= 3'h0;
                phase_ff   <= 1'b0;
                ser_rd_ff  <= 1'b0;
            end else begin
                if (samp_edge) begin
                    rx_sh_ff   <= rx_next;
                    bit_cnt_ff <= bit_cnt_ff + 1'b1;
                    if (bit_cnt_ff == `LMS_BIT_LAST) begin
                        if (!phase_ff) begin
                            phase_ff    <= 1'b1;
                            ser_rd_ff   <= rx_next[7];
                            ser_addr_ff <= rx_next[6:0];
                            tx_sh_ff    <= rd_data_ser(rx_next[6:0]);
                        end else if (!ser_rd_ff) begin
                            ser_wr_ff    <= 1'b1;
                            ser_wdata_ff <= rx_next;
                            phase_ff     <= 1'b0;
                        end else begin
                            phase_ff <= 1'b0;
                            ser_rd_ff <= 1'b0;
                        end
                    end
                end
                // msb goes out first, then the register shifts
                if (lnch_edge && phase_ff && ser_rd_ff) begin
                    sdo_ff   <= tx_sh_ff[7];
                    tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                end
            end
        end
    end

    function [7:0] rd_data_ser;
        input [6:0] a;
        begin
            case (a)
                `LMS_ADDR_GEN_CFG: rd_data_ser = gen_cfg_ff;
                `LMS_ADDR_STATUS:  rd_data_ser = status_val;
                default:           rd_data_ser = `LMS_READ_NONE;
            endcase
        end
    endfunction

    assign SERIAL_OUT    = sdo_ff;
    assign SERIAL_OUT_OE = ser_act & phase_ff & ser_rd_ff;

    // parallel multiplexed port
    reg       ale_p_ff;
    reg [6:0] par_addr_ff;
    reg       par_busy_ff;
    reg       par_wr_ff;
    reg [7:0] par_wdata_ff;
    reg       ack_ff;
    reg [7:0] ad_out_ff;

    wire par_mode = is_moto | is_intel;
    wire par_act  = par_mode & ~s_cs_n;
    wire p_read  = is_moto ? (~s_data_strobe_or_read_n & s_rw_wr_n) : ~s_data_strobe_or_read_n;
    wire p_write = is_moto ? (~s_data_strobe_or_read_n & ~s_rw_wr_n) : ~s_rw_wr_n;
    wire p_strb  = p_read | p_write;

    // latch address, then one access per strobe
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            ale_p_ff     <= 1'b0;
            par_addr_ff  <= 7'h00;
            par_busy_ff  <= 1'b0;
            par_wr_ff    <= 1'b0;
            par_wdata_ff <= 8'h00;
            ack_ff       <= 1'b0;
            ad_out_ff    <= 8'h00;
        end else begin
            ale_p_ff  <= s_ale;
            par_wr_ff <= 1'b0;
            if (par_mode && ale_p_ff && !s_ale) begin
                par_addr_ff <= s_ad[6:0];
            end
            if (!par_act || !p_strb) begin
                par_busy_ff <= 1'b0;
                ack_ff      <= 1'b0;
            end else if (!par_busy_ff) begin
                par_busy_ff <= 1'b1;
                ack_ff      <= 1'b1;
                if (p_write) begin
                    par_wr_ff    <= 1'b1;
                    par_wdata_ff <= s_ad;
                end else begin
                    ad_out_ff <= rd_data;
                end
            end
        end
    end

    assign AD_OUT          = ad_out_ff;
    assign AD_OE           = par_act & p_read & ack_ff;
    // motorola acknowledge is active low, intel ready active high
    assign ACK_OR_READY    = is_moto ? ~ack_ff : ack_ff;
    assign ACK_OR_READY_OE = par_act;

    assign rd_addr = par_addr_ff;
    assign wr_en   = is_serial ? ser_wr_ff : (par_mode & par_wr_ff);
    assign wr_addr = is_serial ? ser_addr_ff : par_addr_ff;
    assign wr_data = is_serial ? ser_wdata_ff : par_wdata_ff;

    // no event source in this block, so the open-drain line stays released
    assign INT_N_OUT = 1'b0;
    assign INT_N_OE  = 1'b0;

    // hardware configuration
    reg [7:0]  gcfg_q_ff;
    reg [3:0]  tpl_ff;
    reg [12:0] hw_ff;
    reg        t1_ff;
    reg        float_ff;

    wire hw_t1 = (s_template != `LMS_TPL_E1_75) && (s_template != `LMS_TPL_E1_120);

    // pins drive config in hardware mode
    always @(posedge REF_CLK) begin
        if (dev_rst) begin
            tpl_ff <= 4'h0;
            hw_ff  <= 13'h0000;
            t1_ff  <= 1'b0;
        end else if (is_hw) begin
            tpl_ff <= s_template;
            hw_ff  <= s_hw_pins;
            t1_ff  <= hw_t1;
        end else begin
            tpl_ff <= 4'h0;
            hw_ff  <= 13'h0000;
            t1_ff  <= gen_cfg_ff[`LMS_BIT_LINE_STD];
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            float_ff  <= 1'b1;
            gcfg_q_ff <= `LMS_GEN_CFG_RST;
        end else begin
            float_ff  <= s_float;
            gcfg_q_ff <= gen_cfg_ff;
        end
    end

    assign line_t1             = t1_ff;
    assign DEVICE_RESET        = dev_rst;
    assign CONTROL_MODE        = mode_ff;
    assign LINE_STANDARD_T1    = t1_ff;
    assign TX_DRIVER_OE        = ~float_ff;
    assign GENERAL_CONFIG      = gcfg_q_ff;
    assign CFG_TEMPLATE        = tpl_ff;
    assign CFG_RECV_CLOCK_EDGE = hw_ff[12];
    assign CFG_LOOPBACK        = hw_ff[11:10];
    assign CFG_TX_SEQUENCE     = hw_ff[9:8];
    assign CFG_JITTER_ATTEN    = hw_ff[7:6];
    assign CFG_MONITOR_GAIN    = hw_ff[5];
    assign CFG_TERM_SEL        = hw_ff[4];
    assign CFG_RECEIVE_GAIN    = hw_ff[3];
    assign CFG_RECEIVER_PD     = hw_ff[2];
    assign CFG_DATAPATH_MODE   = hw_ff[1:0];
endmodule
`default_nettype wire

/* lms_ctrl_mode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lms_ctrl_mode_chk (
    input wire logic       REF_CLK,
    input wire logic       RESET,
    input wire logic       HW_RESET_N,
    input wire logic [1:0] CONTROL_MODE_SELECT,
    input wire logic       DRIVER_FLOAT_CONTROL,
    input wire logic       CHIP_SELECT_N,
    input wire logic [3:0] LINE_TEMPLATE_SELECT,
    input wire logic [1:0] LOOPBACK_SELECT,
    input wire logic       SERIAL_OUT_OE,
    input wire logic       AD_OE,
    input wire logic       ACK_OR_READY_OE,
    input wire logic       DEVICE_RESET,
    input wire logic [1:0] CONTROL_MODE,
    input wire logic       LINE_STANDARD_T1,
    input wire logic       TX_DRIVER_OE,
    input wire logic [7:0] GENERAL_CONFIG,
    input wire logic [3:0] CFG_TEMPLATE,
    input wire logic [1:0] CFG_LOOPBACK
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // saturates so a very long hold never wraps below the threshold
    logic [5:0] low_cnt_ff;
    logic [5:0] nxt_low_cnt;
    wire        hw_run = (CONTROL_MODE == 2'h0) && !DEVICE_RESET;
    wire        sw_run = (CONTROL_MODE != 2'h0) && !DEVICE_RESET;
    always_comb nxt_low_cnt = HW_RESET_N ? 6'h00 : low_cnt_ff + {5'h00, low_cnt_ff != 6'h3F};
    always_ff @(posedge REF_CLK) low_cnt_ff <= RESET ? 6'h00 : nxt_low_cnt;

    property p_drv_on; (!DRIVER_FLOAT_CONTROL && !DEVICE_RESET)[*5] |-> TX_DRIVER_OE; endproperty
    a_drv_on: assert property (p_drv_on) else $error("driver not enabled");
    property p_drv_off; DRIVER_FLOAT_CONTROL[*5] |-> !TX_DRIVER_OE; endproperty
    a_drv_off: assert property (p_drv_off) else $error("driver not floated");
    property p_float_only;
        $changed(DRIVER_FLOAT_CONTROL) |=> $stable(CFG_TEMPLATE) && $stable(LINE_STANDARD_T1)
            && $stable(GENERAL_CONFIG);
    endproperty
    a_float_only: assert property (p_float_only) else $error("float disturbed config");
    property p_mode_dec; !DEVICE_RESET |-> CONTROL_MODE == CONTROL_MODE_SELECT; endproperty
    a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");
    property p_hw_cfg;
        (hw_run && $stable(LINE_TEMPLATE_SELECT) && $stable(LOOPBACK_SELECT))[*5]
            |-> CFG_TEMPLATE == LINE_TEMPLATE_SELECT && CFG_LOOPBACK == LOOPBACK_SELECT;
    endproperty
    a_hw_cfg: assert property (p_hw_cfg) else $error("pin config not taken");
    property p_sw_cfg; sw_run |-> CFG_TEMPLATE == 4'h0 && CFG_LOOPBACK == 2'h0; endproperty
    a_sw_cfg: assert property (p_sw_cfg) else $error("pin config leaks");
    property p_hw_std;
        (hw_run && $stable(LINE_TEMPLATE_SELECT))[*5]
            |-> LINE_STANDARD_T1 == (LINE_TEMPLATE_SELECT > 4'h1);
    endproperty
    a_hw_std: assert property (p_hw_std) else $error("pin standard wrong");
    property p_sw_std;
        (sw_run && $stable(GENERAL_CONFIG))[*3] |-> LINE_STANDARD_T1 == GENERAL_CONFIG[0];
    endproperty
    a_sw_std: assert property (p_sw_std) else $error("register standard wrong");
    property p_rst_long; low_cnt_ff >= 6'h1E |-> DEVICE_RESET; endproperty
    a_rst_long: assert property (p_rst_long) else $error("long reset pulse missed");
    property p_rst_off; HW_RESET_N[*4] |-> !DEVICE_RESET; endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset held too long");
    property p_ser_idle; CHIP_SELECT_N[*4] |-> !SERIAL_OUT_OE; endproperty
    a_ser_idle: assert property (p_ser_idle) else $error("serial out driven idle");
    property p_par_off; CONTROL_MODE == 2'h1 |-> !ACK_OR_READY_OE && !AD_OE; endproperty
    a_par_off: assert property (p_par_off) else $error("parallel bus driven");

    c_float: cover property ($rose(DRIVER_FLOAT_CONTROL));
    c_read: cover property ($rose(SERIAL_OUT_OE));
    c_hwrst: cover property (low_cnt_ff == 6'h1E);
endmodule

bind lms_ctrl_mode lms_ctrl_mode_chk u_chk (
    .REF_CLK, .RESET, .HW_RESET_N, .CONTROL_MODE_SELECT, .DRIVER_FLOAT_CONTROL, .CHIP_SELECT_N,
    .LINE_TEMPLATE_SELECT, .LOOPBACK_SELECT, .SERIAL_OUT_OE, .AD_OE, .ACK_OR_READY_OE,
    .DEVICE_RESET, .CONTROL_MODE, .LINE_STANDARD_T1, .TX_DRIVER_OE, .GENERAL_CONFIG,
    .CFG_TEMPLATE, .CFG_LOOPBACK
);
`default_nettype wire

/* lms_ctrl_regs.vh */
`ifndef LMS_CTRL_REGS_VH
`define LMS_CTRL_REGS_VH

`define LMS_MODE_HW        2'h0
`define LMS_MODE_SERIAL    2'h1
`define LMS_MODE_MOTOROLA  2'h2
`define LMS_MODE_INTEL     2'h3

`define LMS_ADDR_GEN_CFG   7'h02
`define LMS_ADDR_STATUS    7'h03
`define LMS_GEN_CFG_RST    8'h00
`define LMS_BIT_LINE_STD   0
`define LMS_READ_NONE      8'h00

`define LMS_TPL_E1_75      4'h0
`define LMS_TPL_E1_120     4'h1

`define LMS_CLK_PERIOD_PS  4000
`define LMS_RST_MIN_PS     100000
`define LMS_RST_MIN_CYC    ((`LMS_RST_MIN_PS + `LMS_CLK_PERIOD_PS - 1) / `LMS_CLK_PERIOD_PS)
`define LMS_RST_CNT_W      6
`define LMS_BIT_LAST       3'h7

`define LMS_SYNC_W         36

`endif

/* lms_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lms_host_model (
    input  wire logic clk,
    input  wire logic serial_out,
    output var logic  cs_n,
    output var logic  sclk,
    output var logic  edge_sel,
    output var logic  serial_in
);
    initial begin
        cs_n = 1'b1;
        edge_sel = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end
    // six cycles a phase, above the three the port needs
    task automatic ph;
        repeat (6) @(posedge clk);
        #1;
    endtask
    // select, clock on chosen edge, data msb first
    task automatic xfer(input logic e, input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        edge_sel = e;
        sclk = ~e;
        ph;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in = sh[i];
            ph;
            sclk = e;
            rd = {rd[6:0], serial_out};
            ph;
            sclk = ~e;
        end
        ph;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        serial_in = ~serial_in;
    endtask
endmodule
`default_nettype wire

/* lms_sync.v */
`timescale 1ns/1ps
`default_nettype none
module lms_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // no reset: these only ever carry pin levels toward the core
    always @(posedge clk) begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

/* lms_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        REF_CLK;
    logic        RESET;
    logic        HW_RESET_N;
    logic        DRIVER_FLOAT_CONTROL;
    logic [1:0]  CONTROL_MODE_SELECT;
    logic [15:0] pins;
    logic [7:0]  rd;
    int          n_fail;
    int          n_checks;
    wire         cs_n, sclk, edge_sel, serial_in, SERIAL_OUT, DEVICE_RESET, LINE_STANDARD_T1, TX_DRIVER_OE;
    wire  [1:0]  CONTROL_MODE, CFG_LOOPBACK;
    wire  [3:0]  CFG_TEMPLATE;
    wire  [7:0]  GENERAL_CONFIG;
    logic        par_cs_n, ds_n, rw_n, ale;
    logic [7:0]  ad_in;
    wire  [7:0]  ad_out;
    wire         ack, ad_oe, int_oe;

    lms_ctrl_mode DUT (
        .REF_CLK, .RESET, .HW_RESET_N, .CONTROL_MODE_SELECT, .DRIVER_FLOAT_CONTROL,
        .CHIP_SELECT_N(cs_n & par_cs_n), .SERIAL_CLK(sclk), .SERIAL_EDGE_SELECT(edge_sel),
        .SERIAL_IN(serial_in), .SERIAL_OUT, .SERIAL_OUT_OE(), .AD_IN(ad_in), .AD_OUT(ad_out),
        .AD_OE(ad_oe), .DATA_STROBE_OR_READ_N(ds_n), .READ_WRITE_OR_WRITE_N(rw_n),
        .ADDRESS_LATCH_STROBE(ale), .ACK_OR_READY(ack), .ACK_OR_READY_OE(), .INT_N_OUT(),
        .INT_N_OE(int_oe),
        .LINE_TEMPLATE_SELECT(pins[3:0]), .RECV_CLOCK_EDGE_SELECT(pins[4]),
        .LOOPBACK_SELECT(pins[6:5]), .TRANSMIT_SEQUENCE_SELECT(pins[8:7]),
        .JITTER_ATTENUATOR_SELECT(pins[10:9]), .MONITOR_GAIN_SELECT(pins[11]),
        .TERMINATION_SELECT(pins[12]), .RECEIVE_GAIN_RANGE_SELECT(pins[13]),
        .RECEIVER_POWERDOWN(pins[14]), .DATAPATH_OPERATING_MODE({pins[15], pins[4]}),
        .DEVICE_RESET, .CONTROL_MODE, .LINE_STANDARD_T1, .TX_DRIVER_OE, .GENERAL_CONFIG,
        .CFG_TEMPLATE, .CFG_TERM_SEL(), .CFG_RECV_CLOCK_EDGE(), .CFG_LOOPBACK,
        .CFG_TX_SEQUENCE(), .CFG_JITTER_ATTEN(), .CFG_MONITOR_GAIN(), .CFG_RECEIVE_GAIN(),
        .CFG_RECEIVER_PD(), .CFG_DATAPATH_MODE()
    );
    lms_host_model host (.clk(REF_CLK), .serial_out(SERIAL_OUT), .cs_n, .sclk, .edge_sel, .serial_in);

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    // mode straps only move while reset is held
    task automatic do_reset(input logic [1:0] m);
        RESET = 1'b1;
        CONTROL_MODE_SELECT = m;
        cyc(8);
        RESET = 1'b0;
        for (int i = 0; i < 20 && DEVICE_RESET !== 1'b0; i++) cyc(1);
        if (DEVICE_RESET !== 1'b0) begin
            n_fail++;
            finish_test;
        end
        cyc(4);
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            chk({6'h00, CONTROL_MODE}, m[7:0]);
        end
        $display("test modes done");
    endtask
    task automatic t_hw;
        logic [3:0] tpl [4] = '{4'h0, 4'h1, 4'h2, 4'h7};
        do_reset(2'h0);
        for (int i = 0; i < 4; i++) begin
            pins = {i[0] ? 9'h155 : 9'h0AA, i[1:0], 1'b0, tpl[i]};
            cyc(6);
            chk({4'h0, CFG_TEMPLATE}, {4'h0, tpl[i]});
            chk({6'h00, CFG_LOOPBACK}, {6'h00, i[1:0]});
            chk({7'h00, LINE_STANDARD_T1}, {7'h00, tpl[i] > 4'h1});
        end
        $display("test hardware pins done");
    endtask
    task automatic t_float;
        DRIVER_FLOAT_CONTROL = 1'b1;
        cyc(6);
        chk({7'h00, TX_DRIVER_OE}, 8'h00);
        chk({4'h0, CFG_TEMPLATE}, 8'h07);
        host.xfer(1'b1, 8'h02, 8'h01, rd);
        cyc(4);
        chk(GENERAL_CONFIG, 8'h00);
        DRIVER_FLOAT_CONTROL = 1'b0;
        cyc(6);
        chk({7'h00, TX_DRIVER_OE}, 8'h01);
        $display("test driver float done");
    endtask
    task automatic t_hwrst;
        HW_RESET_N = 1'b0;
        cyc(5);
        HW_RESET_N = 1'b1;
        cyc(3);
        chk({7'h00, DEVICE_RESET}, 8'h00);
        HW_RESET_N = 1'b0;
        cyc(34);
        chk({7'h00, DEVICE_RESET}, 8'h01);
        HW_RESET_N = 1'b1;
        cyc(6);
        chk({7'h00, DEVICE_RESET}, 8'h00);
        $display("test pin reset done");
    endtask
    task automatic t_serial;
        do_reset(2'h1);
        for (int e = 0; e < 2; e++) begin
            host.xfer(e[0], 8'h02, 8'h01, rd);
            cyc(4);
            chk(GENERAL_CONFIG, 8'h01);
            chk({7'h00, LINE_STANDARD_T1}, 8'h01);
            host.xfer(e[0], 8'h82, 8'h00, rd);
            chk(rd, 8'h01);
            host.xfer(e[0], 8'h83, 8'h00, rd);
            chk(rd, 8'h05);
            host.xfer(e[0], 8'hFF, 8'h00, rd);
            chk(rd, 8'h00);
            host.xfer(e[0], 8'h02, 8'h00, rd);
            cyc(4);
            chk({7'h00, LINE_STANDARD_T1}, 8'h00);
        end
        $display("test serial port done");
    endtask
    // one multiplexed access: latch address, strobe, wait for acknowledge or ready
    task automatic p_acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                         input logic moto, output logic [7:0] r);
        ad_in = {1'b0, a};
        ale = 1'b1;
        cyc(4);
        ale = 1'b0;
        cyc(4);
        par_cs_n = 1'b0;
        ad_in = d;
        if (moto) begin
            rw_n = ~w;
            ds_n = 1'b0;
        end else if (w) begin
            rw_n = 1'b0;
        end else begin
            ds_n = 1'b0;
        end
        for (int i = 0; i < 10 && ack !== ~moto; i++) cyc(1);
        chk({7'h00, ack}, {7'h00, ~moto});
        chk({7'h00, ad_oe}, {7'h00, ~w});
        r = ad_out;
        ds_n = 1'b1;
        rw_n = 1'b1;
        par_cs_n = 1'b1;
        cyc(6);
    endtask
    task automatic t_par;
        do_reset(2'h3);
        p_acc(1'b1, 7'h02, 8'h01, 1'b0, rd);
        chk(GENERAL_CONFIG, 8'h01);
        p_acc(1'b0, 7'h02, 8'h00, 1'b0, rd);
        chk(rd, 8'h01);
        chk({7'h00, int_oe}, 8'h00);
        do_reset(2'h2);
        p_acc(1'b1, 7'h02, 8'h01, 1'b1, rd);
        chk(GENERAL_CONFIG, 8'h01);
        p_acc(1'b0, 7'h03, 8'h00, 1'b1, rd);
        chk(rd, 8'h06);
        $display("test parallel port done");
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    initial begin
        n_fail = 0;
        n_checks = 0;
        RESET = 1'b1;
        HW_RESET_N = 1'b1;
        DRIVER_FLOAT_CONTROL = 1'b0;
        CONTROL_MODE_SELECT = 2'h0;
        pins = 16'h0000;
        par_cs_n = 1'b1;
        ds_n = 1'b1;
        rw_n = 1'b1;
        ale = 1'b0;
        ad_in = 8'h00;
        t_modes;
        t_hw;
        t_float;
        t_hwrst;
        t_serial;
        t_par;
        finish_test;
    end
    // a hang counts against the run
    initial begin
        #200000;
        n_fail++;
        finish_test;
    end
endmodule
`default_nettype wire
